//--- verilog/nwr_consts.svh
`ifndef NWR_CONSTS_SVH
`define NWR_CONSTS_SVH

// Register offsets
`define NWR_OFF_DAC 8'h10
`define NWR_OFF_WRD 8'h14

// Direct access control fields
`define NWR_B_SK 0
`define NWR_B_CS 1
`define NWR_B_DI 2
`define NWR_B_DO 3
`define NWR_B_FWE 4
`define NWR_B_REQ 6
`define NWR_B_GNT 7
`define NWR_B_PRES 8
`define NWR_B_AUPD 20
`define NWR_B_USEC 22
`define NWR_B_KIND 23

// Word read fields
`define NWR_B_START 0
`define NWR_B_DONE 1
`define NWR_B_ADDR 2
`define NWR_B_DATA 16

// Reset values
`define NWR_FWE_RST 2'h1
`define NWR_DONE_RST 1'h1

// Serial read sequence
`define NWR_OP_READ 3'h6
`define NWR_CMD_LAST 5'h10
`define NWR_DATA_LAST 5'h0F
`define NWR_PH_HIGH 2'h1
`define NWR_PH_LAST 2'h3

`endif

//--- verilog/nwr_pkg.sv
package nwr_pkg;

	typedef struct packed {
		logic di;
		logic cs;
		logic sk;
	} nwr_pins_t;

	typedef struct packed {
		logic [15:0] data;
		logic [13:0] addr;
		logic done;
	} nwr_wrd_t;

	typedef enum logic [1:0] {
		NWR_IDLE = 2'b00,
		NWR_CMD = 2'b01,
		NWR_DATA = 2'b10,
		NWR_FIN = 2'b11
	} nwr_state_t;

endpackage

//--- verilog/nwr_access.sv
`timescale 1ns/1ps
`include "nwr_consts.svh"

// Behaviour
// - upper-sector bit shows which sector is valid
// - memory-kind bit read-only, 0 EEPROM 1 Flash
// - memory-kind informational; strap decides real type
// - serial output sampled on link clock into bit 3
// - start bit launches one 16-bit word read
// - start bit self-clears, always reads zero
// - done low while busy, software writes ignored
// - data field holds fetched word, resets zero
// - fetched word copied nowhere but data field
// - direct access only after request is granted
// - present bit shows attached memory, with or without signature
module nwr_access (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_nvm_do,
	output logic o_nvm_sk,
	output logic o_nvm_cs,
	output logic o_nvm_di,
	input wire logic i_nvm_present,
	input wire logic i_flash_strap,
	input wire logic i_upper_sec_sig,
	input wire logic i_kind_loaded,
	input wire logic i_flash_wr_cycle,
	input wire logic i_flash_timer_exp,
	output logic [1:0] o_flash_wr_ctl,
	output logic o_auto_update_en,
	output logic o_auto_update_go
);

	// System domain: pin and link inputs
	// 0 present, 1 strap, 2 sector sig, 3 kind, 4 serial out, 5 ack toggle
	// Bits synced one by one: each is a slow level, never a word
	localparam int SYS_N = 6;
	logic [SYS_N-1:0] sys_raw;
	logic [SYS_N-1:0] sys_m;
	logic [SYS_N-1:0] sys_s;
	logic ack_seen;
	logic lk_do;
	logic lk_ack;

	assign sys_raw = {lk_ack, lk_do, i_kind_loaded, i_upper_sec_sig,
		i_flash_strap, i_nvm_present};

	genvar gs;
	generate
		for (gs = 0; gs < SYS_N; gs++) begin : g_sys_sync
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					sys_m[gs] <= 1'b0;
					sys_s[gs] <= 1'b0;
				end else begin
					sys_m[gs] <= sys_raw[gs];
					sys_s[gs] <= sys_m[gs];
				end
			end
		end
	endgenerate

	// System domain register state
	nwr_pkg::nwr_pins_t sw;
	nwr_pkg::nwr_pins_t next_sw;
	nwr_pkg::nwr_wrd_t wrd;
	nwr_pkg::nwr_wrd_t next_wrd;
	logic [1:0] flash_write_control;
	logic [1:0] next_fwe;
	logic req;
	logic next_req;
	logic gnt;
	logic next_gnt;
	logic aupd;
	logic next_aupd;
	logic aupd_go;
	logic next_aupd_go;
	logic start_tgl;
	logic next_start_tgl;
	logic next_ack_seen;
	logic [31:0] next_rdata;
	logic [15:0] lk_data;
	logic mem_pres;
	logic usec;
	logic [31:0] dac_view;
	logic [31:0] wrd_view;

	assign mem_pres = sys_s[0];
	// Strap, not the loaded kind bit, names the real type
	assign usec = mem_pres & sys_s[1] & sys_s[2];

	always_comb begin
		dac_view = 32'h0;
		dac_view[`NWR_B_SK] = sw.sk;
		dac_view[`NWR_B_CS] = sw.cs;
		dac_view[`NWR_B_DI] = sw.di;
		dac_view[`NWR_B_DO] = sys_s[4];
		dac_view[`NWR_B_FWE +: 2] = flash_write_control;
		dac_view[`NWR_B_REQ] = req;
		dac_view[`NWR_B_GNT] = gnt;
		dac_view[`NWR_B_PRES] = mem_pres;
		dac_view[`NWR_B_AUPD] = aupd;
		dac_view[`NWR_B_USEC] = usec;
		dac_view[`NWR_B_KIND] = sys_s[3];
	end

	always_comb begin
		wrd_view = 32'h0;
		wrd_view[`NWR_B_START] = 1'b0;
		wrd_view[`NWR_B_DONE] = wrd.done;
		wrd_view[`NWR_B_ADDR +: 14] = wrd.addr;
		wrd_view[`NWR_B_DATA +: 16] = wrd.data;
	end

	always_comb begin
		next_sw = sw;
		next_wrd = wrd;
		next_fwe = flash_write_control;
		next_req = req;
		next_aupd = aupd;
		next_start_tgl = start_tgl;
		next_ack_seen = sys_s[5];
		next_rdata = 32'h0;
		// Grant only while the engine is idle, so the pins have one owner
		next_gnt = req & wrd.done;
		next_aupd_go = aupd & (i_flash_wr_cycle | i_flash_timer_exp);
		if (i_wr) begin
			if (i_addr == `NWR_OFF_DAC) begin
				next_sw.sk = i_wdata[`NWR_B_SK];
				next_sw.cs = i_wdata[`NWR_B_CS];
				next_sw.di = i_wdata[`NWR_B_DI];
				next_fwe = i_wdata[`NWR_B_FWE +: 2];
				next_req = i_wdata[`NWR_B_REQ];
				next_aupd = i_wdata[`NWR_B_AUPD];
			end else if (i_addr == `NWR_OFF_WRD) begin
				// Request alone blocks too, so a grant cannot race a start
				// Busy or granted: the start is dropped
				if (i_wdata[`NWR_B_START] && wrd.done && !gnt && !req) begin
					next_wrd.addr = i_wdata[`NWR_B_ADDR +: 14];
					next_wrd.done = 1'b0;
					next_start_tgl = ~start_tgl;
				end
			end
		end
		// Ack is a toggle so the faster system clock sees each one exactly once
		// Done only rises while busy, so it never meets an accepted start
		if (sys_s[5] != ack_seen) begin
			// Word lands only in the data field
			next_wrd.data = lk_data;
			next_wrd.done = 1'b1;
		end
		// Read data stands for one cycle and is zero otherwise
		if (i_rd) begin
			if (i_addr == `NWR_OFF_DAC) begin
				next_rdata = dac_view;
			end else if (i_addr == `NWR_OFF_WRD) begin
				next_rdata = wrd_view;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sw <= '0;
			wrd <= '{data: 16'h0, addr: 14'h0, done: `NWR_DONE_RST};
			flash_write_control <= `NWR_FWE_RST;
			req <= 1'b0;
			gnt <= 1'b0;
			aupd <= 1'b0;
			aupd_go <= 1'b0;
			start_tgl <= 1'b0;
			ack_seen <= 1'b0;
			o_rdata <= 32'h0;
		end else begin
			sw <= next_sw;
			wrd <= next_wrd;
			flash_write_control <= next_fwe;
			req <= next_req;
			gnt <= next_gnt;
			aupd <= next_aupd;
			aupd_go <= next_aupd_go;
			start_tgl <= next_start_tgl;
			ack_seen <= next_ack_seen;
			o_rdata <= next_rdata;
		end
	end

	assign o_flash_wr_ctl = flash_write_control;
	assign o_auto_update_en = aupd;
	assign o_auto_update_go = aupd_go;

	// Link domain: 0 grant, 1..3 software pins, 4 start toggle, 5 serial out
	// Software pins may land an edge apart; slow bit-banging tolerates it
	localparam int LNK_N = 6;
	logic [LNK_N-1:0] lnk_raw;
	logic [LNK_N-1:0] lnk_m;
	logic [LNK_N-1:0] lnk_s;

	assign lnk_raw = {i_nvm_do, start_tgl, sw, gnt};

	genvar gl;
	generate
		for (gl = 0; gl < LNK_N; gl++) begin : g_lnk_sync
			always_ff @(posedge i_link_clk or posedge i_rst) begin
				if (i_rst) begin
					lnk_m[gl] <= 1'b0;
					lnk_s[gl] <= 1'b0;
				end else begin
					lnk_m[gl] <= lnk_raw[gl];
					lnk_s[gl] <= lnk_m[gl];
				end
			end
		end
	endgenerate

	// Word read engine on the link clock
	// No wait on the memory: an absent part yields whatever the line shows
	nwr_pkg::nwr_state_t st;
	nwr_pkg::nwr_state_t next_st;
	nwr_pkg::nwr_pins_t eng;
	nwr_pkg::nwr_pins_t next_eng;
	nwr_pkg::nwr_pins_t pins;
	nwr_pkg::nwr_pins_t next_pins;
	logic [1:0] ph;
	logic [1:0] next_ph;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [16:0] sh;
	logic [16:0] next_sh;
	logic [15:0] next_lk_data;
	logic start_seen;
	logic next_start_seen;
	logic next_lk_ack;
	logic next_lk_do;

	always_comb begin
		next_st = st;
		next_eng = eng;
		next_ph = ph;
		next_cnt = cnt;
		next_sh = sh;
		next_lk_data = lk_data;
		next_lk_ack = lk_ack;
		next_start_seen = lnk_s[4];
		// Level sampled every link edge for bit 3
		next_lk_do = lnk_s[5];
		case (st)
			nwr_pkg::NWR_IDLE: begin
				next_eng = '0;
				next_ph = 2'h0;
				next_cnt = 5'h0;
				// Address is stable: the system side holds it until done
				if (lnk_s[4] != start_seen) begin
					next_sh = {`NWR_OP_READ, wrd.addr};
					next_st = nwr_pkg::NWR_CMD;
				end
			end
			nwr_pkg::NWR_CMD: begin
				next_ph = ph + 2'h1;
				next_eng.cs = 1'b1;
				next_eng.di = sh[16];
				next_eng.sk = (ph == `NWR_PH_HIGH) | (ph == 2'h2);
				if (ph == `NWR_PH_LAST) begin
					next_sh = {sh[15:0], 1'b0};
					next_cnt = cnt + 5'h1;
					if (cnt == `NWR_CMD_LAST) begin
						next_cnt = 5'h0;
						next_st = nwr_pkg::NWR_DATA;
					end
				end
			end
			nwr_pkg::NWR_DATA: begin
				next_ph = ph + 2'h1;
				next_eng.di = 1'b0;
				next_eng.sk = (ph == `NWR_PH_HIGH) | (ph == 2'h2);
				// Sync delay of two edges fits inside the low phase
				if (ph == `NWR_PH_LAST) begin
					next_lk_data = {lk_data[14:0], lnk_s[5]};
					next_cnt = cnt + 5'h1;
					if (cnt == `NWR_DATA_LAST) begin
						next_st = nwr_pkg::NWR_FIN;
					end
				end
			end
			nwr_pkg::NWR_FIN: begin
				next_eng = '0;
				// Data settled a full link clock before the toggle
				next_lk_ack = ~lk_ack;
				next_st = nwr_pkg::NWR_IDLE;
			end
			default: begin
				next_st = nwr_pkg::NWR_IDLE;
			end
		endcase
		// Software owns the pins only while granted
		next_pins = lnk_s[0] ? nwr_pkg::nwr_pins_t'(lnk_s[3:1]) : eng;
	end

	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= nwr_pkg::NWR_IDLE;
			eng <= '0;
			pins <= '0;
			ph <= 2'h0;
			cnt <= 5'h0;
			sh <= 17'h0;
			lk_data <= 16'h0;
			lk_ack <= 1'b0;
			lk_do <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			st <= next_st;
			eng <= next_eng;
			pins <= next_pins;
			ph <= next_ph;
			cnt <= next_cnt;
			sh <= next_sh;
			lk_data <= next_lk_data;
			lk_ack <= next_lk_ack;
			lk_do <= next_lk_do;
			start_seen <= next_start_seen;
		end
	end

	// Pins leave a flop, so the memory never sees a glitch
	assign o_nvm_sk = pins.sk;
	assign o_nvm_cs = pins.cs;
	assign o_nvm_di = pins.di;

endmodule // nwr_access

//--- verification/nwr_access_properties.sv
`timescale 1ns/1ps
module nwr_access_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_nvm_present,
	input wire logic i_flash_strap,
	input wire logic i_upper_sec_sig,
	input wire logic i_kind_loaded,
	input wire logic i_flash_wr_cycle,
	input wire logic i_flash_timer_exp,
	input wire logic o_auto_update_en,
	input wire logic o_auto_update_go
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic u;
	assign u = i_nvm_present & i_flash_strap & i_upper_sec_sig;
	// Status input true now and six cycles back is taken as a settled synced copy
	sequence rd_s(c);
		i_rd && i_addr == 8'h10 && c && $past(c, 6);
	endsequence
	en_write_a:
		assert property (i_wr && i_addr == 8'h10 |=> o_auto_update_en == $past(i_wdata[20]))
		else $error("enable not loaded");
	update_go_a:
		assert property (i_flash_wr_cycle || i_flash_timer_exp
			|=> o_auto_update_go == $past(o_auto_update_en)) else $error("update go wrong");
	start_zero_a:
		assert property (i_rd && i_addr == 8'h14 |=> !o_rdata[0]) else $error("start reads one");
	upper_one_a:
		assert property (rd_s(u) |=> o_rdata[22]) else $error("upper sector not shown");
	upper_zero_a:
		assert property (rd_s(!u) |=> !o_rdata[22]) else $error("upper sector not clear");
	kind_a:
		assert property (rd_s(i_kind_loaded) |=> o_rdata[23]) else $error("kind bit lost");
	present_a:
		assert property (rd_s(i_nvm_present) |=> o_rdata[8]) else $error("present bit lost");
	absent_a:
		assert property (rd_s(!i_nvm_present) |=> !o_rdata[8]) else $error("present bit stuck");
	update_off_a:
		assert property (!o_auto_update_en |=> !o_auto_update_go)
		else $error("update go while disabled");
endmodule // nwr_access_props

bind nwr_access nwr_access_props u_nwr_access_props (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_nvm_present, .i_flash_strap, .i_upper_sec_sig, .i_kind_loaded,
	.i_flash_wr_cycle, .i_flash_timer_exp, .o_auto_update_en, .o_auto_update_go);

//--- verification/nwr_nvm_model.sv
`timescale 1ns/1ps
module nwr_nvm_model (
	input wire logic i_clk,
	input wire logic i_cs,
	input wire logic i_sk,
	input wire logic i_di,
	output logic o_do
);
	logic [5:0] n;
	logic [16:0] cmd;
	logic [15:0] w;
	assign w = {2'h2, cmd[13:0]} ^ 16'h5A3C;
	initial o_do = 1'h0;
	always @(negedge i_cs) n <= 6'h0;
	always @(posedge i_sk) if (i_cs) begin
		n <= n + 6'h1;
		if (n < 6'h11) cmd <= {cmd[15:0], i_di};
	end
	// Next bit at the falling clock, held through the high phase
	always @(negedge i_sk) if (i_cs && n > 6'h10 && n < 6'h21) o_do <= w[6'h20 - n];
	// Deselected line toggles, so a stale bit never passes for data
	always @(posedge i_clk) if (!i_cs) o_do <= ~o_do;
endmodule // nwr_nvm_model

//--- verification/test_nwr_access.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_nwr_access;
	logic i_clk = 1'h0, i_link_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_nvm_do;
	logic i_nvm_present = 1'h1, i_flash_strap = 1'h0, i_upper_sec_sig = 1'h0;
	logic i_kind_loaded = 1'h0, i_flash_wr_cycle = 1'h0, i_flash_timer_exp = 1'h0;
	logic o_nvm_sk, o_nvm_cs, o_nvm_di, o_auto_update_en, o_auto_update_go;
	logic [1:0] o_flash_wr_ctl;
	logic [7:0] i_addr = 8'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic [16:0] cmd;
	logic [15:0] w;
	int fail_count = 0, checks_done = 0, i, k;
	nwr_access u_nwr_access (.i_clk, .i_rst, .i_link_clk, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_nvm_do, .o_nvm_sk, .o_nvm_cs, .o_nvm_di, .i_nvm_present, .i_flash_strap,
		.i_upper_sec_sig, .i_kind_loaded, .i_flash_wr_cycle, .i_flash_timer_exp,
		.o_flash_wr_ctl, .o_auto_update_en, .o_auto_update_go);
	nwr_nvm_model u_nwr_nvm_model (.i_clk(i_link_clk), .i_cs(o_nvm_cs), .i_sk(o_nvm_sk),
		.i_di(o_nvm_di), .o_do(i_nvm_do));
	always #2.5 i_clk = ~i_clk;
	initial begin
		#7.3;
		forever #16 i_link_clk = ~i_link_clk;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1 d = o_rdata;
	endtask
	task automatic results;
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#300000;
		fail_count++;
		results;
	end
	initial begin
		// Longer than two link periods so the link side sees two edges
		repeat (14) @(posedge i_clk);
		i_rst <= 1'h0;
		repeat (20) @(posedge i_clk);
		rd(8'h14);
		`CHK("read reg", 32'h00000002, d)
		rd(8'h10);
		`CHK("direct reg", 32'h00000110, d & ~32'h8)
		rd(8'h20);
		`CHK("unmapped", 32'h0, d)
		for (i = 0; i < 3; i++) begin
			wr(8'h10, {11'h0, i != 0, 14'h0, i[1:0], 4'h0});
			`CHK("flash ctl", i[1:0], o_flash_wr_ctl)
			@(posedge i_clk);
			i_flash_wr_cycle <= i[0];
			i_flash_timer_exp <= !i[0];
			@(posedge i_clk);
			i_flash_wr_cycle <= 1'h0;
			i_flash_timer_exp <= 1'h0;
			#1 `CHK("auto go", i != 0, o_auto_update_go)
		end
		for (i = 0; i < 16; i++) begin
			@(posedge i_clk);
			{i_nvm_present, i_flash_strap, i_upper_sec_sig, i_kind_loaded} <= i[3:0];
			repeat (10) @(posedge i_clk);
			rd(8'h10);
			`CHK("present", i[3], d[8])
			`CHK("upper sector", &i[3:1], d[22])
			`CHK("kind", i[0], d[23])
		end
		wr(8'h10, 32'h00000050);
		rd(8'h10);
		`CHK("grant", 1'h1, d[7])
		wr(8'h14, 32'h00000001);
		rd(8'h14);
		`CHK("start refused", 1'h1, d[1])
		cmd = {3'h6, 14'h1234};
		w = {2'h2, 14'h1234} ^ 16'h5A3C;
		for (i = 0; i < 33; i++) begin
			k = (i < 17) ? cmd[16 - i] : 0;
			wr(8'h10, 32'h52 | k * 4);
			repeat (50) @(posedge i_clk);
			if (i > 16) begin
				rd(8'h10);
				`CHK("serial out", w[32 - i], d[3])
			end
			wr(8'h10, 32'h53 | k * 4);
			repeat (50) @(posedge i_clk);
		end
		wr(8'h10, 32'h00000050);
		wr(8'h10, 32'h00000010);
		repeat (60) @(posedge i_clk);
		rd(8'h10);
		`CHK("grant drop", 1'h0, d[7])
		for (k = 0; k < 2; k++) begin
			cmd[13:0] = k ? 14'h3FFF : 14'h000F;
			w = {2'h2, cmd[13:0]} ^ 16'h5A3C;
			wr(8'h14, {16'h0, cmd[13:0], 2'h1});
			wr(8'h14, {16'h0, ~cmd[13:0], 2'h3});
			rd(8'h14);
			`CHK("busy", 2'h0, d[1:0])
			for (i = 0; i < 2000 && d[1] !== 1'h1; i++) rd(8'h14);
			`CHK("word", {w, 2'h2}, {d[31:16], d[1:0]})
			`CHK("addr", cmd[13:0], d[15:2])
			rd(8'h10);
			`CHK("kind kept", 32'h00C00110, d & ~32'h8)
			repeat (10) @(posedge i_clk);
			`CHK("pins idle", 3'h0, {o_nvm_cs, o_nvm_sk, o_nvm_di})
		end
		results;
	end
endmodule // test_nwr_access
